/* File: epf_pkg.sv */
// Purpose: Shared constants and carriers for the endpoint flag block
// Assumes: Four data endpoints, index 0..3 for endpoints 2, 4, 6, 8
// Notes: Register indices are word indices; byte address is 4 x index

// ============================================================
// Package
package epf_pkg;

  // Number of data endpoints handled
  localparam int EPF_NUM_EP = 4;

  // Register word indices, one entry per endpoint (ep8..ep2)
  localparam logic [3:0][5:0] EPF_IDX_THR_HI = {6'h18, 6'h16, 6'h14, 6'h12};
  localparam logic [3:0][5:0] EPF_IDX_THR_LO = {6'h19, 6'h17, 6'h15, 6'h13};
  localparam logic [3:0][5:0] EPF_IDX_ISO = {6'h1d, 6'h1c, 6'h1b, 6'h1a};
  localparam logic [5:0] EPF_IDX_FLAGS_24 = 6'h1e;
  localparam logic [5:0] EPF_IDX_FLAGS_68 = 6'h1f;

  // Reset values
  localparam logic [7:0] EPF_RST_THR_HI = 8'h88;
  localparam logic [7:0] EPF_RST_THR_LO = 8'h00;
  localparam logic [2:0] EPF_RST_ISO = 3'h1;

  // Field positions in the threshold high register
  localparam int EPF_HI_DIR_BIT = 7;
  localparam int EPF_HI_SCOPE_BIT = 6;

  // Largest packet count code that is meaningful
  localparam logic [2:0] EPF_THRESHOLD_PACKET_COUNT_MAX = 3'h4;

  // Status nibble layout: {0, prog, empty, full}
  localparam int EPF_ST_PF_BIT = 2;
  localparam int EPF_ST_EF_BIT = 1;
  localparam int EPF_ST_FF_BIT = 0;

  // Static configuration of one endpoint
  typedef struct packed {
    logic is_in;        // 1 = IN endpoint
    logic iso;          // Isochronous endpoint
    logic big;          // 1024-capable endpoint (ep2, ep6)
    logic early_full;   // early_full_option
    logic early_empty;  // early_empty_option
  } epf_ep_cfg_s;

  // Live FIFO counts and raw flags of one endpoint
  typedef struct packed {
    logic [12:0] avail_bytes;  // OUT: bytes readable by the master
    logic [2:0] threshold_packet_count;          // IN: committed packets
    logic [10:0] cur_bytes;    // IN: bytes in packet being filled
    logic empty;
    logic near_empty;          // Exactly one entry held
    logic full;
    logic near_full;           // One entry short of full
  } epf_ep_cnt_s;

  // Decoded threshold
  typedef struct packed {
    logic [2:0] threshold_packet_count;
    logic [12:0] bytes;
  } epf_thr_s;

endpackage : epf_pkg

/* File: epf_flags.sv */
// Purpose: Programmable, empty and full flag logic of four endpoint FIFOs
// Assumes: FIFO counts are synchronous to i_mclk; APB slave, no wait states
// Notes: Flags are registered once per clock from the live counts
`timescale 1ns/100ps

module epf_flags
  import epf_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Device mode
  input wire logic i_high_speed,
  input wire logic i_sync_fifo,
  input wire logic i_flag_irq_en,
  // Per-endpoint configuration and FIFO state
  input wire epf_ep_cfg_s [3:0] i_cfg,
  input wire epf_ep_cnt_s [3:0] i_cnt,
  // Flag outputs
  output logic [3:0] o_prog_flag,
  output logic [3:0] o_empty_flag,
  output logic [3:0] o_full_flag,
  output logic [3:0][1:0] o_iso_threshold_packet_count,
  output logic o_flag_irq
);

  // ============================================================
  // State
  typedef struct packed {
    logic [3:0][7:0] thr_hi;   // threshold_high_register per endpoint
    logic [3:0][7:0] thr_lo;   // threshold_low_register per endpoint
    logic [3:0][2:0] iso;      // iso_in_packet_register fields
    logic [3:0] pf;            // Registered programmable flags
    logic [3:0] ef;            // Registered empty flags
    logic [3:0] ff;            // Registered full flags
    logic [31:0] prdata;       // Read data captured in setup phase
    logic irq;                 // One-cycle flag interrupt
  } epf_state_s;

  epf_state_s st_r;
  epf_state_s st_nxt;

  // ============================================================
  // Functions

  // Split the two threshold registers into packet and byte fields
  function automatic epf_thr_s epf_decode(input logic [7:0] hi,
      input logic [7:0] lo, input logic wide_map, input logic is_in,
      input logic big);
    epf_thr_s t;
    t = '0;
    if (wide_map) begin
      if (big) begin
        if (is_in) begin
          t.threshold_packet_count = hi[5:3];
          t.bytes = {3'h0, hi[1:0], lo};
        end else begin
          t.bytes = {hi[5:3], hi[1:0], lo};
        end
      end else begin
        if (is_in) begin
          t.threshold_packet_count = {1'b0, hi[4:3]};
          t.bytes = {4'h0, hi[0], lo};
        end else begin
          t.bytes = {2'h0, hi[4:3], hi[0], lo};
        end
      end
    end else begin
      if (big) begin
        if (is_in) begin
          t.threshold_packet_count = {hi[0], lo[7:6]};
          t.bytes = {3'h0, hi[1], 3'h0, lo[5:0]};
        end else begin
          t.bytes = {hi[5:3], hi[1:0], lo};
        end
      end else begin
        if (is_in) begin
          t.threshold_packet_count = {1'b0, lo[7:6]};
          t.bytes = {4'h0, hi[0], 2'h0, lo[5:0]};
        end else begin
          t.bytes = {2'h0, hi[4:3], hi[0], lo};
        end
      end
    end
    // Codes above four are not defined; treat them as four
    if (t.threshold_packet_count > EPF_THRESHOLD_PACKET_COUNT_MAX) begin
      t.threshold_packet_count = EPF_THRESHOLD_PACKET_COUNT_MAX;
    end
    return t;
  endfunction : epf_decode

  // Compare count with threshold in the selected direction
  function automatic logic epf_cmp(input logic ge, input logic [15:0] cnt,
      input logic [15:0] thr);
    return ge ? (cnt >= thr) : (cnt <= thr);
  endfunction : epf_cmp

  // ============================================================
  // Next-state logic
  always_comb begin
    logic [5:0] idx;
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd;
    epf_thr_s thr;
    logic [15:0] cnt;
    logic [15:0] lim;
    logic ge;
    logic early_ok;
    idx = i_paddr[7:2];
    setup = i_psel && !i_penable;
    wr = i_psel && i_penable && i_pwrite;
    hit = 1'b0;
    rd = '0;
    thr = '0;
    cnt = '0;
    lim = '0;
    ge = 1'b0;
    early_ok = 1'b0;
    st_nxt = st_r;

    // Per-endpoint register decode and flag evaluation
    for (int k = 0; k < EPF_NUM_EP; k++) begin
      // Threshold registers, one pair per endpoint
      if (idx == EPF_IDX_THR_HI[k]) begin
        hit = 1'b1;
        rd = {24'h0, st_r.thr_hi[k]};
        if (wr) begin
          st_nxt.thr_hi[k] = i_pwdata[7:0];
        end
      end
      if (idx == EPF_IDX_THR_LO[k]) begin
        hit = 1'b1;
        rd = {24'h0, st_r.thr_lo[k]};
        if (wr) begin
          st_nxt.thr_lo[k] = i_pwdata[7:0];
        end
      end
      // Iso packets per interval; an invalid code is not stored
      if (idx == EPF_IDX_ISO[k]) begin
        hit = 1'b1;
        rd = {29'h0, st_r.iso[k]};
        if (wr && i_pwdata[1:0] != 2'h0) begin
          st_nxt.iso[k] = i_pwdata[2:0];
        end
      end

      // Field layout choice, then count selection
      thr = epf_decode(st_r.thr_hi[k], st_r.thr_lo[k],
          i_high_speed || i_cfg[k].iso, i_cfg[k].is_in,
          i_cfg[k].big);
      ge = st_r.thr_hi[k][EPF_HI_DIR_BIT];
      if (!i_cfg[k].is_in) begin
        // OUT: bytes the master can read, scope bit ignored
        cnt = {3'h0, i_cnt[k].avail_bytes};
        lim = {3'h0, thr.bytes};
      end else if (st_r.thr_hi[k][EPF_HI_SCOPE_BIT]) begin
        // Current packet only, packet field ignored
        cnt = {5'h0, i_cnt[k].cur_bytes};
        lim = {3'h0, thr.bytes};
      end else begin
        // Whole FIFO: packets weigh more than bytes
        cnt = {2'h0, i_cnt[k].threshold_packet_count, i_cnt[k].cur_bytes};
        lim = {2'h0, thr.threshold_packet_count, thr.bytes[10:0]};
      end
      st_nxt.pf[k] = epf_cmp(ge, cnt, lim);

      // Early flags only hold for a synchronous FIFO interface
      early_ok = i_sync_fifo;
      st_nxt.ef[k] = (early_ok && i_cfg[k].early_empty && !i_cfg[k].is_in)
          ? (i_cnt[k].empty || i_cnt[k].near_empty)
          : i_cnt[k].empty;
      st_nxt.ff[k] = (early_ok && i_cfg[k].early_full && i_cfg[k].is_in)
          ? (i_cnt[k].full || i_cnt[k].near_full)
          : i_cnt[k].full;
    end

    // Status registers are read only; writes have no effect
    if (idx == EPF_IDX_FLAGS_24) begin
      hit = 1'b1;
      rd = {24'h0, 1'b0, st_r.pf[1], st_r.ef[1], st_r.ff[1],
          1'b0, st_r.pf[0], st_r.ef[0], st_r.ff[0]};
    end
    if (idx == EPF_IDX_FLAGS_68) begin
      hit = 1'b1;
      rd = {24'h0, 1'b0, st_r.pf[3], st_r.ef[3], st_r.ff[3],
          1'b0, st_r.pf[2], st_r.ef[2], st_r.ff[2]};
    end

    // Read data is captured in setup so it comes from a flop
    if (setup) begin
      st_nxt.prdata = hit ? rd : 32'h0;
    end

    // Interrupt when any prog or full flag rises, or an endpoint
    // leaves empty
    st_nxt.irq = i_flag_irq_en && (|(st_nxt.pf & ~st_r.pf)
        || |(st_nxt.ff & ~st_r.ff)
        || |(st_r.ef & ~st_nxt.ef));
  end

  // ============================================================
  // State register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r.thr_hi <= {4{EPF_RST_THR_HI}};
      st_r.thr_lo <= {4{EPF_RST_THR_LO}};
      st_r.iso <= {4{EPF_RST_ISO}};
      st_r.pf <= 4'h0;
      st_r.ef <= 4'hf;
      st_r.ff <= 4'h0;
      st_r.prdata <= 32'h0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs

  // Unmapped address is flagged during the access phase
  logic addr_hit;
  always_comb begin
    addr_hit = 1'b0;
    for (int k = 0; k < EPF_NUM_EP; k++) begin
      if (i_paddr[7:2] == EPF_IDX_THR_HI[k] ||
          i_paddr[7:2] == EPF_IDX_THR_LO[k] ||
          i_paddr[7:2] == EPF_IDX_ISO[k]) begin
        addr_hit = 1'b1;
      end
    end
    if (i_paddr[7:2] == EPF_IDX_FLAGS_24 ||
        i_paddr[7:2] == EPF_IDX_FLAGS_68) begin
      addr_hit = 1'b1;
    end
  end

  assign o_pready = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && !addr_hit;
  assign o_prdata = st_r.prdata;
  assign o_prog_flag = st_r.pf;
  assign o_empty_flag = st_r.ef;
  assign o_full_flag = st_r.ff;
  assign o_flag_irq = st_r.irq;

  // Full speed allows one packet per frame only
  always_comb begin
    for (int k = 0; k < EPF_NUM_EP; k++) begin
      o_iso_threshold_packet_count[k] = i_high_speed ? st_r.iso[k][1:0] : 2'h1;
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  // Each check that watches an endpoint slot uses one whose configuration makes its
  // antecedent reachable; a slot that can never meet the condition would
  // leave the check silent however broken the logic behind it is.

  sequence s_dir_le(k);
    !st_r.thr_hi[k][EPF_HI_DIR_BIT] && !i_cfg[k].is_in;
  endsequence

  chk_le_flag_out: assert property (
    s_dir_le(0) ##0 (i_cnt[0].avail_bytes == 13'h0)
    |=> o_prog_flag[0])
    else $error("prog flag low with zero count in le mode");

  chk_ge_flag_out: assert property (
    (st_r.thr_hi[0][EPF_HI_DIR_BIT] && !i_cfg[0].is_in
     && i_cnt[0].avail_bytes == 13'h1fff) |=> o_prog_flag[0])
    else $error("prog flag low with max count in ge mode");

  chk_scope_ignore: assert property (
    (i_cfg[2].is_in && st_r.thr_hi[2][EPF_HI_SCOPE_BIT]
     && $stable(i_cnt[2].cur_bytes) && $stable(st_r.thr_hi[2])
     && $stable(st_r.thr_lo[2]) && $stable(i_cfg[2]) && $stable(i_high_speed))
    ##1 ($stable(i_cnt[2].cur_bytes) && $stable(st_r.thr_hi[2])
     && $stable(i_cfg[2]) && $stable(st_r.thr_lo[2])
     && $stable(i_high_speed)) |=> $stable(o_prog_flag[2]))
    else $error("packet count changed current-packet flag");

  chk_empty_track: assert property (
    (i_cnt[2].empty) |=> o_empty_flag[2])
    else $error("empty flag missed");

  chk_full_track: assert property (
    (!i_cnt[3].full && !i_cnt[3].near_full) |=> !o_full_flag[3])
    else $error("full flag set without full fifo");

  chk_status_read: assert property (
    (i_psel && !i_penable && i_paddr[7:2] == EPF_IDX_FLAGS_24)
    |=> o_prdata[7:0] == {1'b0, $past(st_r.pf[1]), $past(st_r.ef[1]),
        $past(st_r.ff[1]), 1'b0, $past(st_r.pf[0]), $past(st_r.ef[0]),
        $past(st_r.ff[0])})
    else $error("flag status read data wrong");

  chk_early_sync: assert property (
    (!i_sync_fifo && !i_cnt[0].empty) |=> !o_empty_flag[0])
    else $error("early empty in async mode");

  chk_irq_cause: assert property (
    o_flag_irq |-> $past(i_flag_irq_en))
    else $error("interrupt without enable");

  chk_iso_invalid: assert property (
    (i_psel && i_penable && i_pwrite && i_paddr[7:2] == EPF_IDX_ISO[3]
     && i_pwdata[1:0] == 2'h0) |=> $stable(st_r.iso[3]))
    else $error("invalid iso code stored");

endmodule : epf_flags

/* File: epf_fifo_model.sv */
// Purpose: Behavioural FIFO state of the four endpoints
// Assumes: One fill level per endpoint, in bytes
// Notes: Depth is a plain default, not a device figure
`timescale 1ns/100ps

module epf_fifo_model
  import epf_pkg::*;
#(
  parameter logic [12:0] DEPTH = 13'h0800
)(
  // Fill state chosen by the bench
  input wire logic [3:0][12:0] i_level,
  input wire logic [3:0][2:0] i_threshold_packet_count,
  input wire logic [3:0][10:0] i_cur,
  // Counts and raw flags towards the block
  output epf_ep_cnt_s [3:0] o_cnt
);
  // ==========================================================
  // Flags come from the level alone, so they never disagree
  always_comb begin
    for (int e = 0; e < 4; e++) begin
      o_cnt[e].avail_bytes = i_level[e];
      o_cnt[e].threshold_packet_count = i_threshold_packet_count[e];
      o_cnt[e].cur_bytes = i_cur[e];
      o_cnt[e].empty = (i_level[e] == 13'h0000);
      o_cnt[e].near_empty = (i_level[e] == 13'h0001);
      o_cnt[e].full = (i_level[e] == DEPTH);
      o_cnt[e].near_full = (i_level[e] == DEPTH - 13'h0001);
    end
  end
endmodule : epf_fifo_model

/* File: tb.sv */
// Purpose: Self-checking bench of the endpoint flag block
// Assumes: Zero-wait APB slave, flags one cycle after counts
// Notes: FIFO state comes from a behavioural model
`timescale 1ns/100ps

module tb
  import epf_pkg::*;
();
  // ==========================================================
  // Signals
  localparam logic [12:0] DEPTH = 13'h0800;
  logic i_mclk, i_nrst, psel, penable, pwrite, pready, pslverr;
  logic hs, sync, irq_en, irq, qerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  epf_ep_cfg_s [3:0] cfg;
  epf_ep_cnt_s [3:0] cnt;
  logic [3:0][12:0] lvl;
  logic [3:0][2:0] pk;
  logic [3:0][10:0] cur;
  logic [3:0] pf, ef, ff;
  logic [3:0][1:0] iso;
  int fails, compares, cyc, nirq;

  epf_fifo_model #(.DEPTH(DEPTH)) i_epf_fifo_model (.i_level(lvl),
    .i_threshold_packet_count(pk), .i_cur(cur), .o_cnt(cnt));
  epf_flags i_epf_flags (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_high_speed(hs), .i_sync_fifo(sync),
    .i_flag_irq_en(irq_en), .i_cfg(cfg), .i_cnt(cnt), .o_prog_flag(pf),
    .o_empty_flag(ef), .o_full_flag(ff), .o_iso_threshold_packet_count(iso),
    .o_flag_irq(irq));

  // ==========================================================
  // Clock and hang guard; the run needs far fewer cycles
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, request held until pready is seen
  task automatic apb(input logic wr, input logic [5:0] ix,
                     input logic [7:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge i_mclk);
    penable <= 1'b1;
    @(posedge i_mclk);
    while (pready !== 1'b1) @(posedge i_mclk);
    q = prdata;
    qerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [5:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    chk(q, {24'h0, e});
  endtask : rd

  // New FIFO state, then count interrupt pulses while flags settle
  task automatic setc(input int e, input logic [12:0] l,
                      input logic [2:0] p, input logic [10:0] c);
    @(posedge i_mclk);
    lvl[e] <= l;
    pk[e] <= p;
    cur[e] <= c;
    nirq = 0;
    repeat (4) begin
      @(posedge i_mclk);
      #1;
      nirq += int'(irq === 1'b1);
    end
    // Return on an edge so later input changes land on an edge too
    @(posedge i_mclk);
  endtask : setc

  task automatic flg(input logic [3:0] f, input int e, input logic v);
    chk({31'h0, f[e]}, {31'h0, v});
  endtask : flg

  task automatic end_sim();
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sync, irq_en} = '0;
    {fails, compares} = '0;
    hs = 1'b1;
    lvl = '0;
    pk = '0;
    cur = '0;
    // ep2 OUT big, ep4 OUT, ep6 IN big, ep8 IN
    cfg = {5'b10000, 5'b10100, 5'b00000, 5'b00100};
    i_nrst = 1'b0;
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1'b1;
    for (int e = 0; e < 4; e++) begin
      rd(EPF_IDX_THR_HI[e], 8'h88);
      rd(EPF_IDX_THR_LO[e], 8'h00);
      rd(EPF_IDX_ISO[e], 8'h01);
    end
    rd(EPF_IDX_FLAGS_24, 8'h22);
    rd(EPF_IDX_FLAGS_68, 8'h22);
    apb(1'b0, 6'h3f, 8'h00);
    chk({31'h0, qerr}, 32'h1);
    apb(1'b1, EPF_IDX_FLAGS_24, 8'hff);
    rd(EPF_IDX_FLAGS_24, 8'h22);
    // OUT bytes against 0x100, both directions, scope ignored
    apb(1'b1, EPF_IDX_THR_HI[0], 8'h81);
    setc(0, 13'h00ff, 3'h0, 11'h0);
    flg(pf, 0, 1'b0);
    setc(0, 13'h0100, 3'h0, 11'h0);
    flg(pf, 0, 1'b1);
    setc(0, 13'h1fff, 3'h0, 11'h0);
    flg(pf, 0, 1'b1);
    rd(EPF_IDX_FLAGS_24, 8'h24);
    apb(1'b1, EPF_IDX_THR_HI[0], 8'h41);
    setc(0, 13'h0100, 3'h0, 11'h0);
    flg(pf, 0, 1'b1);
    setc(0, 13'h0101, 3'h7, 11'h0);
    flg(pf, 0, 1'b0);
    setc(0, 13'h0000, 3'h0, 11'h0);
    flg(pf, 0, 1'b1);
    // IN whole FIFO, packet codes 0 to 4
    apb(1'b1, EPF_IDX_THR_LO[2], 8'h10);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, EPF_IDX_THR_HI[2], {2'b10, 3'(k), 3'b000});
      setc(2, 13'h0010, 3'(k), 11'h010);
      flg(pf, 2, 1'b1);
      setc(2, 13'h0010, 3'(k), 11'h00f);
      flg(pf, 2, 1'b0);
    end
    // Undefined packet code weighs as four packets
    apb(1'b1, EPF_IDX_THR_HI[2], 8'hb8);
    setc(2, 13'h0010, 3'h4, 11'h010);
    flg(pf, 2, 1'b1);
    apb(1'b1, EPF_IDX_THR_HI[2], 8'hd8);
    setc(2, 13'h0010, 3'h0, 11'h010);
    flg(pf, 2, 1'b1);
    setc(2, 13'h0010, 3'h4, 11'h010);
    flg(pf, 2, 1'b1);
    // Full speed non-iso layouts
    hs <= 1'b0;
    apb(1'b1, EPF_IDX_THR_HI[1], 8'h80);
    apb(1'b1, EPF_IDX_THR_LO[1], 8'hc0);
    setc(1, 13'h00c0, 3'h0, 11'h0);
    flg(pf, 1, 1'b1);
    setc(1, 13'h00bf, 3'h0, 11'h0);
    flg(pf, 1, 1'b0);
    apb(1'b1, EPF_IDX_THR_HI[3], 8'h80);
    apb(1'b1, EPF_IDX_THR_LO[3], 8'h85);
    setc(3, 13'h0010, 3'h2, 11'h005);
    flg(pf, 3, 1'b1);
    setc(3, 13'h0010, 3'h2, 11'h004);
    flg(pf, 3, 1'b0);
    // High speed iso, small endpoint packet bits
    hs <= 1'b1;
    cfg[3].iso <= 1'b1;
    apb(1'b1, EPF_IDX_THR_HI[3], 8'h90);
    setc(3, 13'h0010, 3'h2, 11'h085);
    flg(pf, 3, 1'b1);
    setc(3, 13'h0010, 3'h1, 11'h3ff);
    flg(pf, 3, 1'b0);
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, EPF_IDX_ISO[3], 8'(c));
      rd(EPF_IDX_ISO[3], 8'(c));
      chk({30'h0, iso[3]}, 32'(c));
    end
    apb(1'b1, EPF_IDX_ISO[3], 8'h00);
    rd(EPF_IDX_ISO[3], 8'h03);
    hs <= 1'b0;
    setc(3, 13'h0010, 3'h1, 11'h3ff);
    chk({30'h0, iso[3]}, 32'h1);
    // Empty and full, plain and early
    setc(0, 13'h0001, 3'h0, 11'h0);
    flg(ef, 0, 1'b0);
    cfg[0].early_empty <= 1'b1;
    setc(0, 13'h0001, 3'h0, 11'h0);
    flg(ef, 0, 1'b0);
    sync <= 1'b1;
    setc(0, 13'h0001, 3'h0, 11'h0);
    flg(ef, 0, 1'b1);
    setc(2, DEPTH - 13'h0001, 3'h0, 11'h0);
    flg(ff, 2, 1'b0);
    cfg[2].early_full <= 1'b1;
    setc(2, DEPTH - 13'h0001, 3'h0, 11'h0);
    flg(ff, 2, 1'b1);
    setc(2, DEPTH, 3'h0, 11'h0);
    flg(ff, 2, 1'b1);
    rd(EPF_IDX_FLAGS_68, 8'h01);
    // Interrupt on a flag rising, only when enabled
    setc(0, 13'h0200, 3'h0, 11'h0);
    setc(0, 13'h0050, 3'h0, 11'h0);
    chk(32'(nirq), 32'h0);
    irq_en <= 1'b1;
    setc(0, 13'h0200, 3'h0, 11'h0);
    setc(0, 13'h0050, 3'h0, 11'h0);
    chk(32'(nirq), 32'h1);
    flg(pf, 0, 1'b1);
    end_sim();
  end
endmodule : tb
